// >>> rtl/twm_master_rx.sv
// Two-wire master receiver engine with control, status and data registers.
// Assumes a slave transmitter on an open-drain bus with pull-ups.
//
// Overview of operation
// - A START must go out before any master operation begins.
// - Read address enters receiver mode, write address enters transmitter mode.
// - Writing one to the step flag clears it and starts the bus action.
// - START is driven only once the bus is seen free.
// - After START the flag sets with status 0x08.
// - After read address and its acknowledge: status 0x38, 0x40 or 0x48.
// - A received byte is valid in the data register once the flag sets.
// - Repeated START requested like START; afterwards status 0x10.
// - After repeated START the bus is kept and any slave may follow.
// - In 0x10 read address keeps receiver, write address selects transmitter.
// - 0x38 lost arbitration: release bus, or retry START when bus frees.
// - In 0x40 clearing the flag receives a byte, ACK per ack enable.
// - In 0x48 clearing sends repeated START, STOP, or STOP then START.
// - In 0x50 clearing receives the next byte, ACK per ack enable.
// - In 0x58 clearing sends repeated START, STOP, or STOP then START.
// - The stop request bit clears itself once STOP has gone out.
// - Data writes while the flag is low are dropped and set collision.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module twm_master_rx
  import twm_pkg::*;
#(
  parameter int HALF_CYC = HALF_CYC_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  localparam logic [15:0] HALF_LD = 16'(HALF_CYC - 1);
  localparam logic [3:0]  LAST    = 4'(BYTE_LAST);

  twm_state_e  state_r;
  logic [15:0] tmr_r;
  logic [3:0]  bit_cnt_r;
  logic [8:0]  sh_r;
  logic [7:0]  rx_sh_r, data_r, status_r;
  logic [1:0]  presc_r;
  logic        flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, ie_r;
  logic        set_pls_r, rx_pls_r, stop_done_r, master_r, rs_r;
  logic        addr_ph_r, mode_rx_r, byte_rx_r, ack_ok_r, ack_sel_r;
  logic        bus_busy_r, scl_oe_r, sda_oe_r, drv_lvl_r;
  logic [1:0]  ln_s, ln_p;
  logic        scl_s, sda_s, sda_p, tdone, wr_ctrl, wr_data, go, lost, ack_in;
  logic [7:0]  byte_code;

  twm_line_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .din     ({scl_in, sda_in}),
    .dsync   (ln_s),
    .dprev   (ln_p)
  );

  assign scl_s   = ln_s[1];
  assign sda_s   = ln_s[0];
  assign sda_p   = ln_p[0];
  assign tdone   = (tmr_r == 16'h0);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_data = reg_wr && (reg_addr == OFS_DATA);
  assign go      = wr_ctrl && reg_wdata[B_FLAG] && reg_wdata[B_EN];
  assign ack_in  = !sda_s;
  assign lost    = sh_r[8] && !sda_s && (byte_rx_r ? bit_cnt_r == LAST : bit_cnt_r != LAST);
  assign byte_code = byte_rx_r ? (!sh_r[8] ? SC_DR_ACK : SC_DR_NACK) :
                     !addr_ph_r ? (ack_in ? SC_DW_ACK : SC_DW_NACK) :
                     mode_rx_r ? (ack_in ? SC_AR_ACK : SC_AR_NACK) :
                     (ack_in ? SC_AW_ACK : SC_AW_NACK);

  assign scl_oe  = scl_oe_r;
  assign sda_oe  = sda_oe_r;
  assign scl_out = drv_lvl_r;
  assign sda_out = drv_lvl_r;

  // ----------------------------------------------------------------------
  // Control register and step flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      {flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, ie_r} <= '0;
      presc_r   <= PRESC_RST;
      drv_lvl_r <= 1'b0;
    end
    else
    begin
      if (set_pls_r)
        flag_r <= 1'b1;
      else if (wr_ctrl && reg_wdata[B_FLAG])
        flag_r <= 1'b0;
      if (wr_ctrl)
      begin
        ack_en_r <= reg_wdata[B_ACK];
        sta_r    <= reg_wdata[B_STA];
        en_r     <= reg_wdata[B_EN];
        ie_r     <= reg_wdata[B_IE];
      end
      if (wr_ctrl && reg_wdata[B_STO])
        sto_r <= 1'b1;
      else if (stop_done_r || wr_ctrl)
        sto_r <= 1'b0;
      if (wr_data && !flag_r)
        wcol_r <= 1'b1;
      else if (wr_data)
        wcol_r <= 1'b0;
      if (reg_wr && reg_addr == OFS_STAT)
        presc_r <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Data register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      data_r <= DATA_RST;
    else if (rx_pls_r)
      data_r <= rx_sh_r;
    else if (wr_data && flag_r)
      data_r <= reg_wdata;
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_CTRL: reg_rdata <= {flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};
        OFS_STAT: reg_rdata <= {status_r[7:3], 1'b0, presc_r};
        OFS_DATA: reg_rdata <= data_r;
        default:  reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------------
  // Bus free tracking from START and STOP on the lines
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      bus_busy_r <= 1'b0;
    else if (scl_s && sda_p && !sda_s)
      bus_busy_r <= 1'b1;
    else if (scl_s && !sda_p && sda_s)
      bus_busy_r <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Bus engine; outside START and STOP, sda changes only a cycle after scl has been pulled low.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      tmr_r   <= 16'h0;
      {set_pls_r, rx_pls_r, stop_done_r, master_r, rs_r} <= '0;
      {addr_ph_r, mode_rx_r, byte_rx_r, ack_ok_r, ack_sel_r} <= '0;
      {scl_oe_r, sda_oe_r} <= '0;
      bit_cnt_r <= 4'h0;
      sh_r      <= 9'h1FF;
      rx_sh_r   <= 8'h00;
      status_r  <= SC_IDLE;
    end
    else
    begin
      set_pls_r   <= 1'b0;
      rx_pls_r    <= 1'b0;
      stop_done_r <= 1'b0;
      if (!tdone)
        tmr_r <= tmr_r - 16'h1;
      // The write that first sets enable may already carry the START request.
      if (!en_r && !go)
      begin
        state_r  <= ST_IDLE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
        master_r <= 1'b0;
      end
      else
      begin
        unique case (state_r)
          ST_IDLE:
            if (go && reg_wdata[B_STA])
            begin
              state_r <= ST_FREE;
              rs_r    <= 1'b0;
              tmr_r   <= HALF_LD;
            end
            else if (go)
              status_r <= SC_IDLE;
          ST_FREE:
            if (bus_busy_r)
              tmr_r <= HALF_LD;
            else if (tdone)
            begin
              state_r  <= ST_STA_A;
              sda_oe_r <= 1'b1;
              tmr_r    <= HALF_LD;
            end
          ST_STA_A:
            if (tdone)
            begin
              state_r  <= ST_STA_B;
              scl_oe_r <= 1'b1;
              tmr_r    <= HALF_LD;
            end
          ST_STA_B:
            if (tdone)
            begin
              state_r   <= ST_HOLD;
              set_pls_r <= 1'b1;
              status_r  <= rs_r ? SC_RSTART : SC_START;
              master_r  <= 1'b1;
              addr_ph_r <= 1'b1;
            end
          ST_HOLD:
            if (go)
            begin
              bit_cnt_r <= 4'h0;
              if (addr_ph_r)
              begin
                sh_r      <= {data_r, 1'b1};
                byte_rx_r <= 1'b0;
                mode_rx_r <= data_r[0];
                state_r   <= ST_LOAD;
              end
              else if (reg_wdata[B_STO])
              begin
                state_r  <= ST_STP_A;
                sda_oe_r <= 1'b1;
                tmr_r    <= HALF_LD;
              end
              else if (reg_wdata[B_STA])
              begin
                state_r  <= ST_RS_A;
                sda_oe_r <= 1'b0;
                tmr_r    <= HALF_LD;
              end
              else if (!mode_rx_r)
              begin
                sh_r      <= {data_r, 1'b1};
                byte_rx_r <= 1'b0;
                state_r   <= ST_LOAD;
              end
              else if (ack_ok_r)
              begin
                sh_r      <= {8'hFF, !reg_wdata[B_ACK]};
                ack_sel_r <= reg_wdata[B_ACK];
                byte_rx_r <= 1'b1;
                state_r   <= ST_LOAD;
              end
            end
          ST_LOAD:
          begin
            sda_oe_r <= !sh_r[8];
            tmr_r    <= HALF_LD;
            state_r  <= ST_LOW;
          end
          ST_LOW:
            if (tdone)
            begin
              state_r  <= ST_HIGH;
              scl_oe_r <= 1'b0;
              tmr_r    <= HALF_LD;
            end
          ST_HIGH:
            if (!scl_s)
              tmr_r <= HALF_LD;
            else if (tdone)
            begin
              if (lost)
              begin
                {scl_oe_r, sda_oe_r, master_r} <= '0;
                status_r  <= SC_LOST;
                set_pls_r <= 1'b1;
                state_r   <= ST_IDLE;
              end
              // hold clock low at byte end
              else if (bit_cnt_r == LAST)
              begin
                scl_oe_r  <= 1'b1;
                set_pls_r <= 1'b1;
                rx_pls_r  <= byte_rx_r;
                status_r  <= byte_code;
                ack_ok_r  <= byte_rx_r ? !sh_r[8] : ack_in;
                addr_ph_r <= 1'b0;
                state_r   <= ST_HOLD;
              end
              else
              begin
                scl_oe_r  <= 1'b1;
                rx_sh_r   <= {rx_sh_r[6:0], sda_s};
                sh_r      <= {sh_r[7:0], 1'b1};
                bit_cnt_r <= bit_cnt_r + 4'h1;
                state_r   <= ST_LOAD;
              end
            end
          ST_STP_A:
            if (tdone)
            begin
              state_r  <= ST_STP_B;
              scl_oe_r <= 1'b0;
              tmr_r    <= HALF_LD;
            end
          ST_STP_B:
            if (!scl_s)
              tmr_r <= HALF_LD;
            else if (tdone)
            begin
              state_r  <= ST_STP_C;
              sda_oe_r <= 1'b0;
              tmr_r    <= HALF_LD;
            end
          ST_STP_C:
            if (tdone)
            begin
              stop_done_r <= 1'b1;
              master_r    <= 1'b0;
              status_r    <= SC_IDLE;
              rs_r        <= 1'b0;
              tmr_r       <= HALF_LD;
              state_r     <= sta_r ? ST_FREE : ST_IDLE;
            end
          ST_RS_A:
            if (tdone)
            begin
              state_r  <= ST_RS_B;
              scl_oe_r <= 1'b0;
              tmr_r    <= HALF_LD;
            end
          ST_RS_B:
            if (!scl_s)
              tmr_r <= HALF_LD;
            else if (tdone)
            begin
              state_r  <= ST_STA_A;
              sda_oe_r <= 1'b1;
              rs_r     <= 1'b1;
              tmr_r    <= HALF_LD;
            end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_start_sent;
    state_r == ST_STA_B && tdone && !rs_r && en_r;
  endsequence
  sequence s_rstart_sent;
    state_r == ST_STA_B && tdone && rs_r && en_r;
  endsequence

  flag_clear_a: assert property (
    wr_ctrl && reg_wdata[B_FLAG] && !set_pls_r |=> !flag_r)
    else $error("step flag not cleared by write of one");
  start_code_a: assert property (
    s_start_sent |-> ##2 (flag_r && status_r == SC_START))
    else $error("start not reported with code 08");
  rstart_code_a: assert property (
    s_rstart_sent |-> ##2 (flag_r && status_r == SC_RSTART))
    else $error("repeated start not reported with code 10");
  write_coll_a: assert property (
    wr_data && !flag_r && !rx_pls_r |=> wcol_r && $stable(data_r))
    else $error("data write with flag low not discarded");
  hold_clock_a: assert property (
    flag_r && master_r |-> scl_oe_r)
    else $error("clock line released while flag set");
  free_wait_a: assert property (
    state_r == ST_FREE && bus_busy_r |=> !sda_oe_r && !scl_oe_r)
    else $error("start driven on busy bus");
  stop_clear_a: assert property (
    stop_done_r && !wr_ctrl |=> !sto_r)
    else $error("stop request not cleared after stop");
  rx_ack_a: assert property (
    state_r == ST_LOW && byte_rx_r && bit_cnt_r == LAST |-> sda_oe_r == ack_sel_r)
    else $error("ack bit does not follow ack enable");
  lost_rel_a: assert property (
    set_pls_r && status_r == SC_LOST |-> !sda_oe_r && !scl_oe_r && !master_r)
    else $error("bus not released after lost arbitration");
  read_mode_a: assert property (
    set_pls_r && status_r == SC_AR_ACK |-> mode_rx_r)
    else $error("read address ack without receiver mode");
  master_entry_a: assert property (
    $rose(master_r) |-> $past(state_r) == ST_STA_B)
    else $error("master role without start");
  rx_data_a: assert property (
    $rose(flag_r) && byte_rx_r && master_r |-> data_r == rx_sh_r)
    else $error("received byte not in data register");

endmodule : twm_master_rx

// >>> rtl/twm_pkg.sv
// Constants, register map and state type of the two-wire master receiver.
// Assumes a 125 MHz system clock and an open-drain two-wire bus outside.
package twm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_STAT = 2'h1;
  localparam logic [1:0] OFS_DATA = 2'h2;

  localparam int B_FLAG = 7;
  localparam int B_ACK  = 6;
  localparam int B_STA  = 5;
  localparam int B_STO  = 4;
  localparam int B_WCOL = 3;
  localparam int B_EN   = 2;
  localparam int B_IE   = 0;

  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'hFF;
  localparam logic [1:0] PRESC_RST = 2'h0;

  // ----------------------------------------------------------------------
  // Status codes, prescaler bits taken as zero
  // ----------------------------------------------------------------------
  localparam logic [7:0] SC_START   = 8'h08;
  localparam logic [7:0] SC_RSTART  = 8'h10;
  localparam logic [7:0] SC_AW_ACK  = 8'h18;
  localparam logic [7:0] SC_AW_NACK = 8'h20;
  localparam logic [7:0] SC_DW_ACK  = 8'h28;
  localparam logic [7:0] SC_DW_NACK = 8'h30;
  localparam logic [7:0] SC_LOST    = 8'h38;
  localparam logic [7:0] SC_AR_ACK  = 8'h40;
  localparam logic [7:0] SC_AR_NACK = 8'h48;
  localparam logic [7:0] SC_DR_ACK  = 8'h50;
  localparam logic [7:0] SC_DR_NACK = 8'h58;
  localparam logic [7:0] SC_IDLE    = 8'hF8;

  // ----------------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS       = 8;
  localparam int T_HALF_NS    = 5000;
  localparam int HALF_CYC_DEF = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int BYTE_LAST    = 8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FREE, ST_STA_A, ST_STA_B, ST_HOLD, ST_LOAD, ST_LOW, ST_HIGH,
    ST_STP_A, ST_STP_B, ST_STP_C, ST_RS_A, ST_RS_B
  } twm_state_e;

endpackage : twm_pkg

// >>> rtl/twm_line_sync.sv
// Two-flop synchroniser for the bus lines, with one further stage for edges.
// Assumes asynchronous inputs from the two-wire pins.
`timescale 1ns/1ps
module twm_line_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dsync,
  output logic      [W-1:0] dprev
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------------
  // Synchroniser chain; lines idle high
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      meta_r <= '1;
      dsync  <= '1;
      dprev  <= '1;
    end
    else
    begin
      meta_r <= din;
      dsync  <= meta_r;
      dprev  <= dsync;
    end
  end

endmodule : twm_line_sync

// >>> verif/twm_slave_model.sv
// Behavioural slave transmitter on the two-wire bus, used by the bench.
// Assumes pulled-up lines that the bench resolves from every party's enable.
`timescale 1ns/1ps
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] TX0  = 8'hA5,
  parameter int         STR  = 300
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  output logic      scl_oe,
  output logic      sda_oe
);
  logic [7:0] sh;
  logic [7:0] tx;
  int         bitn;
  logic       act;
  logic       ab;
  logic       rd;

  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    act    = 1'b0;
  end

  always @(negedge sda)
    if (scl)
    begin
      act  = 1'b1;
      ab   = 1'b1;
      rd   = 1'b0;
      bitn = 0;
      tx   = TX0;
    end

  always @(posedge sda)
    if (scl)
      act = 1'b0;

  always @(posedge scl)
    if (act)
    begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      if (bitn == 8)
      begin
        if (ab)
        begin
          rd  = sh[0];
          act = (sh[7:1] == ADDR);
        end
        else if (rd)
        begin
          act = ~sda;
          tx  = tx + 8'h01;
        end
        ab   = 1'b0;
        bitn = 0;
      end
      else
        bitn++;
    end

  // Data changes only while the clock line is low; optional stretching.
  always @(negedge scl)
  begin
    if (!act)
      sda_oe = 1'b0;
    else if (bitn == 8)
      sda_oe = ab ? (sh[7:1] == ADDR) : ~rd;
    else
      sda_oe = rd & ~tx[7 - bitn];
    if (slow && act)
    begin
      scl_oe = 1'b1;
      #(STR);
      scl_oe = 1'b0;
    end
  end
endmodule : twm_slave_model

// >>> verif/testbench.sv
// Self-checking bench for the two-wire master receiver with a slave model.
// Assumes open-drain lines with pull-ups, resolved here from all enables.
`timescale 1ns/1ps
module testbench;
  import twm_pkg::*;

  localparam logic [6:0] SADDR = 7'h2A;
  localparam logic [7:0] TX0   = 8'hA5;

  typedef struct {
    logic       wr;
    logic [1:0] a;
    logic [7:0] d;
  } twm_row_s;

  logic       clk_sys   = 1'b0;
  logic       reset_n   = 1'b0;
  logic [1:0] reg_addr  = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       slow      = 1'b0;
  logic       ext_sda   = 1'b0;
  logic [7:0] reg_rdata;
  logic       scl_oe;
  logic       sda_oe;
  logic       s_scl_oe;
  logic       s_sda_oe;
  logic       scl_w;
  logic       sda_w;
  logic       scl_lvl;
  logic       sda_lvl;
  logic [7:0] d;
  int         error_cnt = 0;
  int         checks    = 0;
  twm_row_s   rows [12];

  assign scl_w = ~(scl_oe | s_scl_oe);
  assign sda_w = ~(sda_oe | s_sda_oe | ext_sda);

  always #4 clk_sys = ~clk_sys;

  twm_master_rx #(.HALF_CYC(8)) i_twm_master_rx (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .scl_in    (scl_w),
    .scl_out   (scl_lvl),
    .scl_oe    (scl_oe),
    .sda_in    (sda_w),
    .sda_out   (sda_lvl),
    .sda_oe    (sda_oe)
  );

  twm_slave_model #(.ADDR(SADDR), .TX0(TX0)) i_twm_slave_model (
    .scl    (scl_w),
    .sda    (sda_w),
    .slow   (slow),
    .scl_oe (s_scl_oe),
    .sda_oe (s_sda_oe)
  );

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic wait_for(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    rd(a, d);
    while ((d & m) !== e && n < 3000)
    begin
      rd(a, d);
      n++;
    end
    chk8(d & m, e);
  endtask : wait_for

  // Writes the control register, waits for the step flag, checks status.
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    wr(OFS_CTRL, c);
    wait_for(OFS_CTRL, 8'h80, 8'h80);
    rd(OFS_STAT, d);
    chk8(d & 8'hF8, st);
    chk8({5'h00, sda_lvl, scl_lvl, scl_oe}, 8'h01);
  endtask : step

  task automatic stop_chk();
    wr(OFS_CTRL, 8'h94);
    wait_for(OFS_STAT, 8'hF8, 8'hF8);
    rd(OFS_CTRL, d);
    chk8(d & 8'h90, 8'h00);
    chk8({6'h00, scl_w, sda_w}, 8'h03);
  endtask : stop_chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    rows = '{'{1'b0, OFS_CTRL, 8'h00}, '{1'b0, OFS_STAT, 8'hF8}, '{1'b0, OFS_DATA, 8'hFF},
             '{1'b0, 2'h3, 8'h00}, '{1'b1, OFS_STAT, 8'h03}, '{1'b0, OFS_STAT, 8'hFB},
             '{1'b1, OFS_STAT, 8'h00}, '{1'b1, 2'h3, 8'h5A}, '{1'b0, 2'h3, 8'h00},
             '{1'b1, OFS_DATA, 8'h55}, '{1'b0, OFS_DATA, 8'hFF}, '{1'b0, OFS_CTRL, 8'h08}};
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rows[i])
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      else
      begin
        rd(rows[i].a, d);
        chk8(d, rows[i].d);
      end
    $display("test registers done");
    step(8'hA4, SC_START);
    wr(OFS_DATA, {SADDR, 1'b1});
    rd(OFS_CTRL, d);
    chk8(d & 8'h08, 8'h00);
    step(8'hC4, SC_AR_ACK);
    step(8'hC4, SC_DR_ACK);
    rd(OFS_DATA, d);
    chk8(d, TX0);
    step(8'h84, SC_DR_NACK);
    rd(OFS_DATA, d);
    chk8(d, TX0 + 8'h01);
    step(8'hA4, SC_RSTART);
    wr(OFS_DATA, {SADDR + 7'h01, 1'b1});
    step(8'h84, SC_AR_NACK);
    stop_chk();
    $display("test read done");
    slow    <= 1'b1;
    // A foreign START keeps the bus busy until its STOP; ours must wait.
    ext_sda <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fork
      begin
        repeat (40) @(posedge clk_sys);
        chk8({6'h00, scl_oe, sda_oe}, 8'h00);
        ext_sda <= 1'b0;
      end
      step(8'hA4, SC_START);
    join
    wr(OFS_DATA, {SADDR, 1'b1});
    step(8'h84, SC_AR_ACK);
    step(8'h84, SC_DR_NACK);
    rd(OFS_DATA, d);
    chk8(d, TX0);
    step(8'hB4, SC_START);
    wr(OFS_DATA, {SADDR, 1'b0});
    step(8'h84, SC_AW_ACK);
    stop_chk();
    $display("test slow done");
    slow <= 1'b0;
    wr(OFS_CTRL, 8'hA4);
    repeat (12) @(posedge clk_sys);
    chk8({7'h00, sda_oe}, 8'h01);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk8({6'h00, scl_oe, sda_oe}, 8'h00);
    rd(OFS_CTRL, d);
    chk8(d, 8'h00);
    rd(OFS_STAT, d);
    chk8(d, SC_IDLE);
    $display("test reset done");
    end_of_test();
  end

  initial
  begin
    #300us;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : testbench
